// ---- logic/drpc_host.sv ----
// apb-controlled host driving the converter's parallel and control pins
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module drpc_host
    import drpc_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [15:0] data_o,
    output logic      [15:0] data_oe_o,
    output logic             sel_n_o,
    output logic             dir_read_o,
    output logic             output_update_strobe_o,
    output logic             clear_o,
    output logic             clear_level_select_o,
    output logic             sleep_select_hi_o,
    output logic             sleep_select_lo_o,
    output logic             code_format_select_o
);
    import drpc_pkg::*;

    drpc_pulse_if pif ();
    drpc_pulse_timer u_timer (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .pif        (pif.timer)
    );

    logic [3:0]  ctrl_q;
    logic [3:0]  ctrl_d;
    logic [15:0] word_q;
    logic [15:0] word_d;
    logic [2:0]  cmd_q;
    logic [2:0]  cmd_d;
    logic [12:0] settle_q;
    logic [12:0] settle_d;
    drpc_state_e st_q;
    drpc_state_e st_d;
    logic        started_q;
    logic        started_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : hit

    logic wr_acc;
    logic busy;
    assign wr_acc = psel && penable && pwrite;
    assign busy   = (st_q != DRPC_IDLE) || (cmd_q != 3'h0);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit(paddr, DRPC_OFF_CTRL) ||
                     hit(paddr, DRPC_OFF_DATA) || hit(paddr, DRPC_OFF_CMD) ||
                     hit(paddr, DRPC_OFF_STATUS));

    always_comb begin
        prdata = 32'h0000_0000;
        if (hit(paddr, DRPC_OFF_CTRL)) begin
            prdata = {28'h0, ctrl_q};
        end else if (hit(paddr, DRPC_OFF_DATA)) begin
            prdata = {16'h0, word_q};
        end else if (hit(paddr, DRPC_OFF_STATUS)) begin
            prdata = {30'h0, settle_q != 13'h0, busy};
        end
    end

    // register writes; exit wait armed when sleep selects return to 00
    always_comb begin
        ctrl_d   = ctrl_q;
        word_d   = word_q;
        settle_d = (settle_q != 13'h0) ? settle_q - 13'h1 : settle_q;
        if (wr_acc && hit(paddr, DRPC_OFF_CTRL)) begin
            ctrl_d = pwdata[3:0];
            if ((ctrl_q[DRPC_CTRL_SLEEP1] || ctrl_q[DRPC_CTRL_SLEEP0]) &&
                !pwdata[DRPC_CTRL_SLEEP1] && !pwdata[DRPC_CTRL_SLEEP0]) begin
                settle_d = 13'(EXIT_WAIT_CYC);
            end
        end
        if (wr_acc && hit(paddr, DRPC_OFF_DATA)) begin
            word_d = pwdata[15:0];
        end
    end

    // sequencer: clear first, then input write, then load
    always_comb begin
        st_d      = st_q;
        cmd_d     = cmd_q;
        started_d = started_q;
        pif.start = 1'b0;
        if (wr_acc && hit(paddr, DRPC_OFF_CMD)) begin
            cmd_d = cmd_q | pwdata[2:0];
        end
        case (st_q)
            DRPC_IDLE: begin
                started_d = 1'b0;
                if (cmd_d[DRPC_CMD_CLEAR]) begin
                    st_d = DRPC_CLEAR;
                    cmd_d[DRPC_CMD_CLEAR] = 1'b0;
                end else if (cmd_d[DRPC_CMD_WRITE]) begin
                    st_d = DRPC_SEL;
                    cmd_d[DRPC_CMD_WRITE] = 1'b0;
                end else if (cmd_d[DRPC_CMD_LOAD]) begin
                    st_d = DRPC_LOAD;
                    cmd_d[DRPC_CMD_LOAD] = 1'b0;
                end
            end
            DRPC_SEL, DRPC_LOAD, DRPC_CLEAR: begin
                pif.start = !started_q;
                started_d = 1'b1;
                if (started_q && !pif.active) begin
                    st_d = DRPC_DONE;
                end
            end
            DRPC_DONE: begin
                st_d = DRPC_IDLE;
            end
            default: begin
                st_d = DRPC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q    <= DRPC_CTRL_RST;
            word_q    <= DRPC_DATA_RST;
            cmd_q     <= 3'h0;
            settle_q  <= 13'h0;
            st_q      <= DRPC_IDLE;
            started_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            word_q    <= word_d;
            cmd_q     <= cmd_d;
            settle_q  <= settle_d;
            st_q      <= st_d;
            started_q <= started_d;
        end
    end

    // pins: select pulses low and rises at the end of its pulse; load and clear pulse high and rise at the start
    logic pulse_on;
    assign pulse_on = started_q && pif.active;
    assign sel_n_o  = !(st_q == DRPC_SEL && pulse_on);
    assign output_update_strobe_o = (st_q == DRPC_LOAD) && pulse_on;
    assign clear_o  = (st_q == DRPC_CLEAR) && pulse_on;
    assign dir_read_o = 1'b0;
    assign data_o    = word_q;
    assign data_oe_o = {16{1'b1}};
    assign clear_level_select_o = ctrl_q[DRPC_CTRL_CLRSEL];
    assign sleep_select_hi_o    = ctrl_q[DRPC_CTRL_SLEEP1];
    assign sleep_select_lo_o    = ctrl_q[DRPC_CTRL_SLEEP0];
    assign code_format_select_o = ctrl_q[DRPC_CTRL_FMT];

    sequence s_sel_low;
        !sel_n_o [*2];
    endsequence
    sequence s_clear_high;
        clear_o [*2];
    endsequence
    sequence s_load_high;
        (output_update_strobe_o && sel_n_o) [*2];
    endsequence
    a_sel_pulse_width: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(sel_n_o) |-> s_sel_low ##1 sel_n_o)
        else $error("select pulse width wrong");
    a_data_stable_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !sel_n_o |-> $stable(data_o) && !dir_read_o)
        else $error("data moved during select");
    a_load_no_sel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(output_update_strobe_o) |-> s_load_high ##1 !output_update_strobe_o)
        else $error("load pulse wrong or overlaps select");
    a_clear_excl: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        clear_o |-> !output_update_strobe_o && sel_n_o)
        else $error("clear overlaps other strobe");
    a_clear_width: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(clear_o) |-> s_clear_high ##1 !clear_o)
        else $error("clear pulse width wrong");
    a_exit_wait_arm: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(sleep_select_hi_o | sleep_select_lo_o) |-> settle_q == 13'(EXIT_WAIT_CYC))
        else $error("exit wait not armed");
    a_sleep_map: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (wr_acc && hit(paddr, DRPC_OFF_CTRL)) |=>
        {sleep_select_hi_o, sleep_select_lo_o} ==
        $past({pwdata[DRPC_CTRL_SLEEP1], pwdata[DRPC_CTRL_SLEEP0]}))
        else $error("sleep select mismatch");
    a_clear_first: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == DRPC_IDLE && cmd_q[DRPC_CMD_CLEAR]) |=> st_q == DRPC_CLEAR)
        else $error("clear not given precedence");
endmodule : drpc_host

// ---- logic/drpc_pkg.sv ----
// constants and types for the converter host controller
package drpc_pkg;
    // register byte offsets on apb
    localparam logic [7:0] DRPC_OFF_CTRL   = 8'h00;
    localparam logic [7:0] DRPC_OFF_DATA   = 8'h04;
    localparam logic [7:0] DRPC_OFF_CMD    = 8'h08;
    localparam logic [7:0] DRPC_OFF_STATUS = 8'h0C;
    // ctrl field positions
    localparam int DRPC_CTRL_CLRSEL = 0;
    localparam int DRPC_CTRL_SLEEP0 = 1;
    localparam int DRPC_CTRL_SLEEP1 = 2;
    localparam int DRPC_CTRL_FMT    = 3;
    localparam logic [3:0] DRPC_CTRL_RST = 4'h0;
    // cmd field positions
    localparam int DRPC_CMD_WRITE = 0;
    localparam int DRPC_CMD_LOAD  = 1;
    localparam int DRPC_CMD_CLEAR = 2;
    // status field positions
    localparam int DRPC_ST_BUSY   = 0;
    localparam int DRPC_ST_SETTLE = 1;
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int STROBE_NS     = 40;
    localparam int EXIT_WAIT_NS  = 5000;
    localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXIT_WAIT_CYC = (EXIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] DRPC_DATA_RST = 16'h0000;
    typedef enum logic [2:0] {
        DRPC_IDLE  = 3'b000,
        DRPC_SEL   = 3'b001,
        DRPC_LOAD  = 3'b011,
        DRPC_CLEAR = 3'b010,
        DRPC_DONE  = 3'b110
    } drpc_state_e;
endpackage : drpc_pkg

// ---- logic/drpc_pulse_if.sv ----
// strobe request/done handshake between sequencer and pulse timer
`timescale 1ns/1ps
interface drpc_pulse_if;
    logic start;
    logic active;
    modport ctrl (output start, input active);
    modport timer (input start, output active);
endinterface : drpc_pulse_if

// ---- logic/drpc_pulse_timer.sv ----
// fixed-width strobe timer
`timescale 1ns/1ps
module drpc_pulse_timer
    import drpc_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    drpc_pulse_if.timer pif
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (pif.start && cnt_q == 8'h00) begin
            cnt_d = 8'(STROBE_CYC);
        end else if (cnt_q != 8'h00) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign pif.active = (cnt_q != 8'h00);
endmodule : drpc_pulse_timer

// ---- verif/drpc_dev_model.sv ----
// behavioural converter device on the host's pins
`timescale 1ns/1ps
module drpc_dev_model (
    input  wire logic        sel_n_i,
    input  wire logic        dir_read_i,
    input  wire logic [15:0] data_i,
    input  wire logic        update_i,
    input  wire logic        clear_i,
    input  wire logic        clr_lvl_i,
    input  wire logic        sleep_hi_i,
    input  wire logic        sleep_lo_i,
    input  wire logic        fmt_i,
    output logic      [15:0] hold_o,
    output logic      [15:0] level_o,
    output logic      [1:0]  mode_o,
    output logic             driven_o
);
    // level_o is the output as an unsigned scale position
    initial level_o = 16'h0000;
    always @(posedge sel_n_i) begin
        if (!dir_read_i) hold_o = data_i;
    end
    always @(posedge clear_i or posedge update_i) begin
        if (clear_i) level_o = clr_lvl_i ? 16'h8000 : 16'h0000;
        else level_o = fmt_i ? hold_o ^ 16'h8000 : hold_o;
    end
    assign mode_o   = {sleep_hi_i, sleep_lo_i};
    assign driven_o = (mode_o == 2'b00);
endmodule : drpc_dev_model

// ---- verif/testbench.sv ----
// self-checking bench for the converter host controller
`timescale 1ns/1ps
module testbench;
    import drpc_pkg::*;
    logic        core_clk_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hC7DB92DD, c;
    logic        pready, pslverr, err, sel_n, dir_rd, upd, clr, clv, shi, slo, fmt, drv;
    logic [15:0] data, oe, hold, level, w, lv;
    logic [1:0]  mode;
    int          fails = 0, samples_checked = 0;
    always #10 core_clk_i = ~core_clk_i;
    drpc_host u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .data_o(data), .data_oe_o(oe), .sel_n_o(sel_n),
        .dir_read_o(dir_rd), .output_update_strobe_o(upd), .clear_o(clr),
        .clear_level_select_o(clv), .sleep_select_hi_o(shi), .sleep_select_lo_o(slo),
        .code_format_select_o(fmt));
    drpc_dev_model u_dev (.sel_n_i(sel_n), .dir_read_i(dir_rd), .data_i(data), .update_i(upd),
        .clear_i(clr), .clr_lvl_i(clv), .sleep_hi_i(shi), .sleep_lo_i(slo), .fmt_i(fmt),
        .hold_o(hold), .level_o(level), .mode_o(mode), .driven_o(drv));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // code to unsigned scale position for the selected format
    function automatic logic [15:0] scale_pos(input logic [15:0] code, input logic twos);
        return twos ? code ^ 16'h8000 : code;
    endfunction : scale_pos
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk_i);
        penable <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cmd(input logic [31:0] bits);
        apb(1'b1, DRPC_OFF_CMD, bits);
        do apb(1'b0, DRPC_OFF_STATUS, 32'h0); while (rd[DRPC_ST_BUSY] !== 1'b0);
    endtask : cmd
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    initial begin
        #400000;
        fails++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, DRPC_OFF_CTRL, 32'h0);
        chk("ctrl_reset", {28'h0, DRPC_CTRL_RST}, rd);
        chk("level_power_up", 32'h0, {16'h0, level});
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        apb(1'b1, DRPC_OFF_STATUS, 32'hFFFFFFFF);
        apb(1'b0, DRPC_OFF_STATUS, 32'h0);
        chk("status_ro", 32'h0, rd);
        chk("dir_oe", {15'h0, 1'b0, 16'hFFFF}, {15'h0, dir_rd, oe});
        for (int i = 0; i < 12; i++) begin
            w = 16'(xs());
            c = xs();
            if (i < 2) w = i ? 16'hFFFF : 16'h0000;
            apb(1'b1, DRPC_OFF_CTRL, {28'h0, c[3], 2'b00, c[0]});
            @(negedge core_clk_i);
            chk("ctrl_pins", {30'h0, c[3], c[0]}, {30'h0, fmt, clv});
            apb(1'b1, DRPC_OFF_DATA, {16'h0, w});
            cmd(32'h1 << DRPC_CMD_WRITE);
            chk("hold_write", {16'h0, w}, {16'h0, hold});
            cmd(32'h1 << DRPC_CMD_LOAD);
            lv = scale_pos(w, c[3]);
            chk("level_load", {16'h0, lv}, {16'h0, level});
            cmd(32'h1 << DRPC_CMD_CLEAR);
            chk("level_clear", {16'h0, c[0], 15'h0}, {16'h0, level});
            chk("hold_kept", {16'h0, w}, {16'h0, hold});
            cmd((32'h1 << DRPC_CMD_CLEAR) | (32'h1 << DRPC_CMD_LOAD));
            chk("clear_then_load", {16'h0, lv}, {16'h0, level});
            // clear and load queued behind a running write: clear must go first
            apb(1'b1, DRPC_OFF_CMD, 32'h1 << DRPC_CMD_WRITE);
            cmd((32'h1 << DRPC_CMD_CLEAR) | (32'h1 << DRPC_CMD_LOAD));
            chk("queued_clear_load", {16'h0, lv}, {16'h0, level});
        end
        for (int m = 1; m < 4; m++) begin
            apb(1'b1, DRPC_OFF_CTRL, {28'h0, 1'b0, m[1], m[0], 1'b0});
            @(negedge core_clk_i);
            chk("sleep_mode", m, {30'h0, mode});
            chk("out_driven", 32'h0, {31'h0, drv});
            apb(1'b1, DRPC_OFF_CTRL, 32'h0);
            apb(1'b0, DRPC_OFF_STATUS, 32'h0);
            chk("exit_wait_on", 32'h1, {31'h0, rd[DRPC_ST_SETTLE]});
            chk("level_kept", {16'h0, lv}, {16'h0, level});
            repeat (190) @(posedge core_clk_i);
            apb(1'b0, DRPC_OFF_STATUS, 32'h0);
            chk("exit_wait_mid", 32'h1, {31'h0, rd[DRPC_ST_SETTLE]});
            repeat (60) @(posedge core_clk_i);
            apb(1'b0, DRPC_OFF_STATUS, 32'h0);
            chk("exit_wait_off", 32'h0, {31'h0, rd[DRPC_ST_SETTLE]});
        end
        conclude();
    end
endmodule : testbench
